// >>> rtl/spe_pkg.sv
// =====================================================================
// Shared constants and types for the serial EEPROM command front end
// =====================================================================
package spe_pkg;

  // ===================================================================
  // Clocking and programming time
  // ===================================================================
  localparam int SYS_CLK_NS = 50;
  localparam int T_PROG_NS = 5000000;
  // Longest time, so the count rounds down
  localparam int PROG_CYC = T_PROG_NS / SYS_CLK_NS;

  // ===================================================================
  // Frame layout, counted in bits
  // ===================================================================
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] OPC_LAST = 5'h07;
  localparam logic [CNT_W-1:0] ADDR_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] BYTE_LAST = 5'h07;
  localparam logic [2:0] BIT_MSB = 3'h7;
  // Pin idle levels {wp, pause, si, sck, cs}, so release shows no activity
  localparam logic [4:0] PIN_IDLE = 5'h1b;
  localparam int ADDR_FIELD_W = 16;

  // ===================================================================
  // Opcodes: upper nibble zero, bit 3 ignored, low three bits decoded
  // ===================================================================
  localparam logic [3:0] OPC_UPPER = 4'h0;
  localparam logic [2:0] CMD_READ = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_SET_LATCH = 3'h6;
  localparam logic [2:0] CMD_CLR_LATCH = 3'h4;
  localparam logic [2:0] CMD_STATUS_READ = 3'h5;
  localparam logic [2:0] CMD_STATUS_WRITE = 3'h1;

  // ===================================================================
  // Status byte layout
  // ===================================================================
  localparam int ST_PIN_EN = 7;
  localparam int ST_BP_HI = 3;
  localparam int ST_BP_LO = 2;
  localparam int ST_WEL = 1;
  localparam int ST_BUSY = 0;
  localparam logic [7:0] STATUS_BUSY_VIEW = 8'hff;
  localparam logic [7:0] STATUS_INIT = 8'h00;

  // ===================================================================
  // Block protect encodings
  // ===================================================================
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  localparam logic [1:0] TOP_QUARTER = 2'h3;

  // ===================================================================
  // Types
  // ===================================================================
  typedef enum logic [2:0] {
    PH_OPC = 3'b000,
    PH_ADDR = 3'b001,
    PH_DIN = 3'b010,
    PH_DOUT = 3'b011,
    PH_SKIP = 3'b100
  } spe_phase_type;

  typedef enum logic [1:0] {
    K_READ = 2'b00,
    K_WRITE = 2'b01,
    K_SREAD = 2'b10,
    K_SWRITE = 2'b11
  } spe_kind_type;

  typedef struct packed {
    logic [ADDR_FIELD_W-1:0] addr;
    logic [7:0] data;
  } spe_wr_word_type;

endpackage : spe_pkg

// >>> rtl/spe_pair_buf.sv
`timescale 1ns/100ps
// =====================================================================
// Small shift-style buffer; the head always sits in entry zero
// =====================================================================
module spe_pair_buf #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [WIDTH-1:0] mem_sh [DEPTH];
  logic [DEPTH-1:0] vld_sh;
  logic pop;
  logic push;

  // Head comes straight from a flop, so the outputs stay registered
  assign out_valid = vld_r[0];
  assign out_data = mem_r[0];
  assign in_ready = ~vld_r[DEPTH-1];
  assign pop = vld_r[0] & out_ready;
  assign push = in_valid & in_ready;

  // =====================================================================
  // Shift down on pop, before the push picks its slot
  // =====================================================================
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      if (pop) begin
        mem_sh[i] = (i == DEPTH - 1) ? mem_r[i] : mem_r[i+1];
        vld_sh[i] = (i == DEPTH - 1) ? 1'b0 : vld_r[i+1];
      end else begin
        mem_sh[i] = mem_r[i];
        vld_sh[i] = vld_r[i];
      end
    end
  end

  // Push lands in the first free slot after the shift
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vld_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && !vld_sh[i] && (i == 0 || vld_sh[(i == 0) ? 0 : i-1])) begin
          mem_r[i] <= in_data;
          vld_r[i] <= 1'b1;
        end else begin
          mem_r[i] <= mem_sh[i];
          vld_r[i] <= vld_sh[i];
        end
      end
    end
  end

endmodule : spe_pair_buf

// >>> rtl/spe_front.sv
`timescale 1ns/100ps
// Behaviour
// - After select falls, sample input on each rising serial clock, MSB first.
// - Select high: input ignored, output released to high impedance.
// - Bad opcode: rest of frame ignored, output released until reselect.
// - Frame is 8-bit opcode, then 16-bit address, then data bytes.
// - Pause low suspends the transfer; serial clock edges ignored meanwhile.
// - Master keeps select low through whole input and output.
// - Array read 0000X011, array write 0000X010, each with 16-bit address.
// - Status read 0000X101 shifts out eight status bits, no address.
// - Status write 0000X001 takes next eight bits as status.
// - Set-latch command sets write latch; clear-latch command clears it.
// - Write latch clear after power-up; writes only accepted while set.
// - Status: bit7 pin enable, bits 3:2 block protect, bit1 latch, bit0 busy.
// - Busy and latch bits not writable; busy high during programming.
// - Protect bits programmed like cells; latch must be set first.
// - Block protect covers none, quarter, half or all; such writes refused.
// - Pin enable set and protect pin low: status writes refused.
// - Pin enable clear: protect pin ignored for status writes.
// - Protect pin high: writes limited only by latch and block protect.
// - Protect pin low during status write input rejects that write.
// - Protect pin falling mid-programming does not stop the cycle.
// - Write latch clears itself when programming completes.
// - Protect 01 top quarter, 10 top half, 11 whole array.
// - While programming only status read accepted, and it returns all ones.
module spe_front #(
  parameter int ADDR_W = 13,
  parameter int PROG_CYCLES = spe_pkg::PROG_CYC,
  parameter int BUF_DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_si,
  input wire logic spi_pause_n,
  input wire logic wp_n,
  output logic spi_so,
  output logic spi_so_oe_n,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output spe_pkg::spe_wr_word_type wr_word,
  output logic prog_busy
);

  localparam int PROG_CW = $clog2(PROG_CYCLES + 1);
  localparam int SYNC_N = 5;

  // =====================================================================
  // Pin synchronisers
  // =====================================================================
  logic [SYNC_N-1:0] meta_r;
  logic [SYNC_N-1:0] sync_r;
  logic sck_d_r;
  logic cs_d_r;
  logic cs_s;
  logic sck_s;
  logic si_s;
  logic pause_s;
  logic wp_s;

  // Two flops on every pin; only the second is read by logic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= spe_pkg::PIN_IDLE;
      sync_r <= spe_pkg::PIN_IDLE;
    end else begin
      meta_r <= {wp_n, spi_pause_n, spi_si, spi_sck, spi_cs_n};
      sync_r <= meta_r;
    end
  end

  assign cs_s = sync_r[0];
  assign sck_s = sync_r[1];
  assign si_s = sync_r[2];
  assign pause_s = sync_r[3];
  assign wp_s = sync_r[4];

  // Delayed copies for edge finding
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_r <= 1'b1; // Idle high like the pin, so no false edge
      cs_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_s;
    end
  end

  // =====================================================================
  // Edge qualification
  // =====================================================================
  logic rise_act;
  logic fall_act;
  logic cs_rise;

  // Edges count only while selected and not paused
  assign rise_act = sck_s & ~sck_d_r & ~cs_s & pause_s;
  assign fall_act = ~sck_s & sck_d_r & ~cs_s & pause_s;
  assign cs_rise = cs_s & ~cs_d_r;

  // =====================================================================
  // Frame state
  // =====================================================================
  spe_pkg::spe_phase_type phase_r;
  spe_pkg::spe_kind_type kind_r;
  logic [spe_pkg::CNT_W-1:0] cnt_r;
  logic [15:0] shift_r;
  logic [15:0] addr_r;
  logic [7:0] data_r;
  logic have_byte_r;
  logic wp_low_seen_r;

  // Status and programming state, declared early for decode
  logic busy_r;
  logic pend_r;
  logic wel_r;
  logic pin_en_r;
  logic [1:0] bp_r;
  logic [PROG_CW-1:0] prog_cnt_r;
  logic busy_any;

  logic [7:0] op_byte;
  logic [15:0] addr_word;
  logic cmd_ok;
  logic opc_done;
  logic wel_set;
  logic wel_clr;

  assign op_byte = {shift_r[6:0], si_s};
  assign addr_word = {shift_r[14:0], si_s};
  assign busy_any = busy_r | pend_r;
  assign opc_done = rise_act && phase_r == spe_pkg::PH_OPC && cnt_r == spe_pkg::OPC_LAST;
  // Busy lets only the status read through
  assign cmd_ok = op_byte[7:4] == spe_pkg::OPC_UPPER
                  && (!busy_any || op_byte[2:0] == spe_pkg::CMD_STATUS_READ);
  assign wel_set = opc_done && cmd_ok && op_byte[2:0] == spe_pkg::CMD_SET_LATCH;
  assign wel_clr = opc_done && cmd_ok && op_byte[2:0] == spe_pkg::CMD_CLR_LATCH;

  // Shift register: opcode in the low byte, address in the full word
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
    end else if (cs_s) begin
      shift_r <= '0;
    end else if (rise_act) begin
      shift_r <= addr_word;
    end
  end

  // Phase machine; select high always restarts at the opcode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= spe_pkg::PH_OPC;
      kind_r <= spe_pkg::K_READ;
      cnt_r <= spe_pkg::CNT_ZERO;
    end else if (cs_s) begin
      phase_r <= spe_pkg::PH_OPC;
      cnt_r <= spe_pkg::CNT_ZERO;
    end else if (rise_act) begin
      cnt_r <= cnt_r + spe_pkg::CNT_ONE;
      unique case (phase_r)
        spe_pkg::PH_OPC: begin
          if (cnt_r == spe_pkg::OPC_LAST) begin
            cnt_r <= spe_pkg::CNT_ZERO;
            phase_r <= spe_pkg::PH_SKIP;
            if (cmd_ok) begin
              unique case (op_byte[2:0])
                spe_pkg::CMD_READ: begin
                  phase_r <= spe_pkg::PH_ADDR;
                  kind_r <= spe_pkg::K_READ;
                end
                spe_pkg::CMD_WRITE: begin
                  phase_r <= spe_pkg::PH_ADDR;
                  kind_r <= spe_pkg::K_WRITE;
                end
                spe_pkg::CMD_STATUS_READ: begin
                  phase_r <= spe_pkg::PH_DOUT;
                  kind_r <= spe_pkg::K_SREAD;
                end
                spe_pkg::CMD_STATUS_WRITE: begin
                  phase_r <= spe_pkg::PH_DIN;
                  kind_r <= spe_pkg::K_SWRITE;
                end
                default: begin
                  // Latch commands finish here; the rest are invalid
                  phase_r <= spe_pkg::PH_SKIP;
                end
              endcase
            end
          end
        end
        spe_pkg::PH_ADDR: begin
          if (cnt_r == spe_pkg::ADDR_LAST) begin
            cnt_r <= spe_pkg::CNT_ZERO;
            phase_r <= (kind_r == spe_pkg::K_READ) ? spe_pkg::PH_DOUT : spe_pkg::PH_DIN;
          end
        end
        spe_pkg::PH_DIN: begin
          if (cnt_r == spe_pkg::BYTE_LAST) begin
            cnt_r <= spe_pkg::CNT_ZERO;
          end
        end
        spe_pkg::PH_DOUT: begin
          // Input is ignored while data goes out
          cnt_r <= spe_pkg::CNT_ZERO;
        end
        spe_pkg::PH_SKIP: begin
          cnt_r <= spe_pkg::CNT_ZERO;
        end
        default: begin
          phase_r <= spe_pkg::PH_SKIP;
        end
      endcase
    end
  end

  // Address capture; also presented to the array for reads
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= '0;
    end else if (rise_act && phase_r == spe_pkg::PH_ADDR && cnt_r == spe_pkg::ADDR_LAST) begin
      addr_r <= addr_word;
    end
  end

  // First data byte is kept; page buffering lives elsewhere
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= '0;
      have_byte_r <= 1'b0;
    end else if (cs_s) begin
      have_byte_r <= 1'b0;
    end else if (rise_act && phase_r == spe_pkg::PH_DIN && cnt_r == spe_pkg::BYTE_LAST) begin
      if (!have_byte_r) begin
        data_r <= op_byte;
      end
      have_byte_r <= 1'b1;
    end
  end

  // Any low level of the protect pin during input is remembered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_low_seen_r <= 1'b0;
    end else if (cs_s) begin
      wp_low_seen_r <= 1'b0;
    end else if (!wp_s) begin
      wp_low_seen_r <= 1'b1;
    end
  end

  // =====================================================================
  // Commit decisions at the end of a frame
  // =====================================================================
  logic frame_whole;
  logic prot_hit;
  logic pin_lock;
  logic mem_commit;
  logic st_commit;
  logic [1:0] top_bits;

  // Commit only when select rises right on a byte boundary
  assign frame_whole = phase_r == spe_pkg::PH_DIN && cnt_r == spe_pkg::CNT_ZERO && have_byte_r;
  assign top_bits = addr_r[ADDR_W-1 -: 2];

  // Block protect against the two top address bits
  always_comb begin
    unique case (bp_r)
      spe_pkg::BP_NONE: prot_hit = 1'b0;
      spe_pkg::BP_QUARTER: prot_hit = top_bits == spe_pkg::TOP_QUARTER;
      spe_pkg::BP_HALF: prot_hit = top_bits[1];
      spe_pkg::BP_ALL: prot_hit = 1'b1;
    endcase
  end

  // Pin only counts when its enable bit is set
  assign pin_lock = pin_en_r & (~wp_s | wp_low_seen_r);
  assign mem_commit = cs_rise && frame_whole && kind_r == spe_pkg::K_WRITE
                      && wel_r && !prot_hit;
  assign st_commit = cs_rise && frame_whole && kind_r == spe_pkg::K_SWRITE
                     && wel_r && !pin_lock;

  // =====================================================================
  // Write buffer toward the array
  // =====================================================================
  spe_pkg::spe_wr_word_type pend_word_r;
  logic buf_in_ready;
  logic push;

  // Held commit waits for room, so a stalled array loses no word
  assign push = pend_r & buf_in_ready;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      pend_word_r <= '0;
    end else if (mem_commit) begin
      pend_r <= 1'b1;
      pend_word_r <= {addr_r, data_r};
    end else if (push) begin
      pend_r <= 1'b0;
    end
  end

  spe_pair_buf #(
    .WIDTH($bits(spe_pkg::spe_wr_word_type)),
    .DEPTH(BUF_DEPTH)
  ) u_wr_buf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(pend_r),
    .in_ready(buf_in_ready),
    .in_data(pend_word_r),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

  // =====================================================================
  // Programming cycle and status bits
  // =====================================================================
  logic prog_done;

  assign prog_done = busy_r && prog_cnt_r == '0;

  // Timer runs to its end whatever the protect pin does
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      prog_cnt_r <= '0;
    end else if (push || st_commit) begin
      busy_r <= 1'b1;
      prog_cnt_r <= PROG_CW'(PROG_CYCLES - 1);
    end else if (prog_done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      prog_cnt_r <= prog_cnt_r - 1'b1;
    end
  end

  // Latch starts clear; a command after completion wins in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_r <= 1'b0;
    end else begin
      if (prog_done) begin
        wel_r <= 1'b0;
      end
      if (wel_clr) begin
        wel_r <= 1'b0;
      end
      if (wel_set) begin
        wel_r <= 1'b1;
      end
    end
  end

  // Only the programmable bits take the written value
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_en_r <= spe_pkg::STATUS_INIT[spe_pkg::ST_PIN_EN];
      bp_r <= spe_pkg::STATUS_INIT[spe_pkg::ST_BP_HI:spe_pkg::ST_BP_LO];
    end else if (st_commit) begin
      pin_en_r <= data_r[spe_pkg::ST_PIN_EN];
      bp_r <= data_r[spe_pkg::ST_BP_HI:spe_pkg::ST_BP_LO];
    end
  end

  // =====================================================================
  // Serial output
  // =====================================================================
  logic [7:0] status_view;
  logic [7:0] src_byte;
  logic [2:0] bit_idx_r;
  logic so_r;
  logic so_oe_n_r;

  // Busy shows all ones rather than the live byte
  always_comb begin
    status_view = '0;
    status_view[spe_pkg::ST_PIN_EN] = pin_en_r;
    status_view[spe_pkg::ST_BP_HI:spe_pkg::ST_BP_LO] = bp_r;
    status_view[spe_pkg::ST_WEL] = wel_r;
    status_view[spe_pkg::ST_BUSY] = busy_any;
    if (busy_any) begin
      status_view = spe_pkg::STATUS_BUSY_VIEW;
    end
  end

  assign src_byte = (kind_r == spe_pkg::K_SREAD) ? status_view : rd_data;

  // New bit after each falling edge, ready for the next rise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      so_r <= 1'b0;
      bit_idx_r <= spe_pkg::BIT_MSB;
    end else if (cs_s) begin
      bit_idx_r <= spe_pkg::BIT_MSB;
    end else if (fall_act && phase_r == spe_pkg::PH_DOUT) begin
      so_r <= src_byte[bit_idx_r];
      bit_idx_r <= bit_idx_r - 1'b1;
    end
  end

  // Released when deselected, paused or not in an output phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      so_oe_n_r <= 1'b1;
    end else begin
      so_oe_n_r <= ~(phase_r == spe_pkg::PH_DOUT && !cs_s && pause_s);
    end
  end

  // =====================================================================
  // Registered outputs
  // =====================================================================
  logic prog_busy_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_busy_r <= 1'b0;
    end else begin
      prog_busy_r <= busy_any;
    end
  end

  assign spi_so = so_r;
  assign spi_so_oe_n = so_oe_n_r;
  assign rd_addr = addr_r[ADDR_W-1:0];
  assign prog_busy = prog_busy_r;

endmodule : spe_front

// >>> tb/spe_front_props.sv
`timescale 1ns/100ps
// ========
// Port-level checks on the command front end
module spe_front_props #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_pause_n,
  input wire logic spi_so,
  input wire logic spi_so_oe_n,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire spe_pkg::spe_wr_word_type wr_word,
  input wire logic prog_busy
);
  int busy_cnt;
  // Busy length in a counter, too long for a repetition
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) busy_cnt <= 0;
    else busy_cnt <= prog_busy ? busy_cnt + 1 : 0;
  end
  // Sync delay allows a few cycles before the pin is released
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_idle_hiz; spi_cs_n [*6] |-> spi_so_oe_n; endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("so driven while deselected");
  property p_pause_hiz; !spi_pause_n [*6] |-> spi_so_oe_n; endproperty
  a_pause_hiz: assert property (p_pause_hiz) else $error("so driven while paused");
  property p_oe_cause; $fell(spi_so_oe_n) |-> !spi_cs_n && spi_pause_n; endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("so enabled without select");
  property p_so_edge; !spi_so_oe_n && !$past(spi_so_oe_n) && $changed(spi_so) |-> !spi_sck; endproperty
  a_so_edge: assert property (p_so_edge) else $error("so changed in clock high phase");
  property p_wr_hold; wr_valid && !wr_ready |=> wr_valid && $stable(wr_word); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("stalled word lost");
  property p_commit; $rose(wr_valid) |-> spi_cs_n; endproperty
  a_commit: assert property (p_commit) else $error("write before deselect");
  property p_busy_on; $rose(wr_valid) |-> ##[0:1] prog_busy; endproperty
  a_busy_on: assert property (p_busy_on) else $error("busy missing");
  property p_busy_len; $fell(prog_busy) |-> busy_cnt >= PROG_CYCLES - 1; endproperty
  a_busy_len: assert property (p_busy_len) else $error("programming cut short");
endmodule : spe_front_props
bind spe_front spe_front_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_pause_n(spi_pause_n), .spi_so(spi_so),
  .spi_so_oe_n(spi_so_oe_n), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
  .prog_busy(prog_busy));

// >>> tb/spe_spi_master.sv
`timescale 1ns/100ps
// ========
// Master stand-in: clock idles high, data moves on the fall
module spe_spi_master (
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe_n,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic pause_n
);
  logic [7:0] rx;
  logic oe;
  // A released line shows the inverse, so stale data never passes
  wire so_line = so_oe_n ? ~so : so;
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    si = 1'b0;
    pause_n = 1'b1;
  end
  // One frame, MSB first; bit pz gets a pause with stray clocks
  task automatic xfer(input logic [31:0] tx, input int n, input int pz = -1);
    oe = 1'b0;
    rx = 8'h00;
    @(posedge clk) cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      sck <= 1'b0;
      si <= tx[i];
      // Pause long enough that the paused-release check really fires
      if (i == pz) begin
        @(posedge clk) pause_n <= 1'b0;
        repeat (6) @(posedge clk) sck <= ~sck;
        @(posedge clk) pause_n <= 1'b1;
      end
      repeat (5) @(posedge clk);
      @(negedge clk);
      rx = {rx[6:0], so_line};
      oe = oe | ~so_oe_n;
      @(posedge clk) sck <= 1'b1;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : spe_spi_master

// >>> tb/tb.sv
`timescale 1ns/100ps
// ========
// Bench for the command front end
module tb;
  logic sys_clk, rst_n, wp_n, wr_ready, cs_n, sck, si, pause_n, so, so_oe_n, wr_valid, prog_busy;
  logic [12:0] rd_addr;
  spe_pkg::spe_wr_word_type wr_word;
  int n_mismatch = 0, checks_done = 0;
  // Array stand-in: data is a fixed function of the address
  wire [7:0] rd_data = rd_addr[7:0] ^ 8'ha5;
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  spe_front #(.PROG_CYCLES(400)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .spi_cs_n(cs_n), .spi_sck(sck),
    .spi_si(si), .spi_pause_n(pause_n), .wp_n(wp_n), .spi_so(so), .spi_so_oe_n(so_oe_n), .rd_addr(rd_addr),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .prog_busy(prog_busy));
  spe_spi_master m (.clk(sys_clk), .so(so), .so_oe_n(so_oe_n), .cs_n(cs_n), .sck(sck), .si(si), .pause_n(pause_n));
  // ========
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish(input bit hung);
    n_mismatch += hung;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // Status read paused before its last bit, so every status read crosses a pause
  task automatic status_read_cmd(input logic [7:0] exp);
    m.xfer(32'h0500, 16, 0);
    chk(m.rx, exp);
  endtask : status_read_cmd
  // Busy may start several cycles after deselect; bounded wait
  task automatic wait_idle;
    repeat (8) @(posedge sys_clk);
    for (int k = 0; prog_busy !== 1'b0; k++) begin
      if (k == 3000) tally_and_finish(1'b1);
      @(posedge sys_clk);
    end
  endtask : wait_idle
  task automatic wsr(input logic [7:0] v);
    m.xfer(32'h06, 8);
    m.xfer({8'h01, v}, 16);
    wait_idle();
  endtask : wsr
  // ========
  // Scenarios
  task automatic t_latch;
    status_read_cmd(8'h00);
    m.xfer(32'h0e, 8);
    status_read_cmd(8'h02);
    m.xfer(32'h04, 8);
    status_read_cmd(8'h00);
    m.xfer(32'h0f06, 16);
    chk(m.oe, 1'b0);
    chk(so_oe_n, 1'b1);
    status_read_cmd(8'h00);
  endtask : t_latch
  // Protect pin falls while the status write programs; it must still finish
  task automatic t_status;
    m.xfer(32'h06, 8);
    m.xfer(32'h01ff, 16);
    @(posedge sys_clk) wp_n <= 1'b0;
    status_read_cmd(8'hff);
    wait_idle();
    status_read_cmd(8'h8c);
    @(posedge sys_clk) wp_n <= 1'b0;
    wsr(8'h00);
    status_read_cmd(8'h8e);
    @(posedge sys_clk) wp_n <= 1'b1;
    wsr(8'h04);
    status_read_cmd(8'h04);
    @(posedge sys_clk) wp_n <= 1'b0;
    wsr(8'h08);
    status_read_cmd(8'h08);
  endtask : t_status
  // Half array protected; stalled write, protected write, then a read
  task automatic t_array;
    @(posedge sys_clk) wr_ready <= 1'b0;
    m.xfer(32'h06, 8);
    m.xfer(32'h020ffe5a, 32);
    repeat (40) @(posedge sys_clk);
    chk(wr_valid, 1'b1);
    chk(wr_word, 32'h0ffe5a);
    @(posedge sys_clk) wr_ready <= 1'b1;
    wait_idle();
    status_read_cmd(8'h08);
    m.xfer(32'h06, 8);
    m.xfer(32'h0a10005a, 32);
    repeat (40) @(posedge sys_clk);
    chk({wr_valid, prog_busy}, 2'b00);
    m.xfer(32'h0b012300, 32);
    chk(m.rx, 8'h86);
    chk(rd_addr, 13'h0123);
  endtask : t_array
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    wr_ready = 1'b1;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_latch();
    t_status();
    t_array();
    tally_and_finish(1'b0);
  end
endmodule : tb
